// File: design/pscr_top.sv
// PCI status/command configuration register with its two writers.
// Assumes the internal peripheral bus runs on core_clk_i and the PCI
// configuration port and transaction engines run on pci_clk_i.
`timescale 1ns/1ps

module pscr_top (
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic sw_reset_i,
    input wire logic ipb_wr_i,
    input wire logic [3:0] ipb_be_i,
    input wire logic [pscr_pkg::PSCR_W-1:0] ipb_wdata_i,
    output logic [pscr_pkg::PSCR_W-1:0] ipb_rdata_o,
    input wire logic pci_clk_i,
    input wire logic pci_cfg_wr_i,
    input wire logic [3:0] pci_cfg_be_i,
    input wire logic [pscr_pkg::PSCR_W-1:0] pci_cfg_wdata_i,
    output logic pci_cfg_busy_o,
    output logic [pscr_pkg::PSCR_W-1:0] pci_cfg_rdata_o,
    input wire logic [pscr_pkg::EV_W-1:0] pci_event_i,
    input wire logic serr_req_i,
    input wire logic perr_req_i,
    input wire logic master_req_i,
    input wire logic mem_hit_i,
    input wire logic io_hit_i,
    output logic master_grant_o,
    output logic target_claim_o,
    output logic stepping_enable_o,
    output logic fast_b2b_enable_o,
    output logic serr_n_o,
    output logic serr_oe_o,
    output logic perr_n_o,
    output logic perr_oe_o
);
    import pscr_pkg::*;

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [31:0] be_mask(input logic [3:0] be);
        be_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    endfunction

    // Flags cleared by ones, plain bits replaced, fixed bits untouched
    function automatic logic [31:0] apply_write(input logic [31:0] cur,
            input logic [31:0] wd, input logic [3:0] be,
            input logic [31:0] rw_mask);
        logic [31:0] m;
        m = be_mask(be);
        apply_write = cur & ~(PSCR_W1C_MASK & wd & m);
        apply_write = (apply_write & ~(rw_mask & m)) | (wd & rw_mask & m);
    endfunction

    // ----------------------------------------
    // Core domain state
    // ----------------------------------------
    logic [31:0] reg_reg, reg_next;
    logic [31:0] rdata_reg, rdata_next;
    logic [2:0] wreq_sync_reg;
    logic wack_reg, wack_next;
    logic [EV_W-1:0] ev_s1_reg, ev_s2_reg, ev_s3_reg;
    logic [EV_W-1:0] ev_pulse;
    logic snd_reg, snd_next;
    logic [1:0] rack_sync_reg;
    logic [31:0] snap_reg, snap_next;
    logic [31:0] ev_set, clr_vec, wr_val;
    logic pci_wr_take;

    // PCI domain state
    logic [1:0] prst_reg;
    logic wreq_reg, wreq_next;
    logic [1:0] wack_sync_reg;
    logic [31:0] pwd_reg, pwd_next;
    logic [3:0] pbe_reg, pbe_next;
    logic [EV_W-1:0] ev_tgl_reg, ev_tgl_next;
    logic [2:0] snd_sync_reg;
    logic rack_reg, rack_next;
    logic [31:0] prd_reg, prd_next;
    logic [CMD_W-1:0] cmd_s1_reg, cmd_s2_reg;
    logic serr_oe_reg, serr_oe_next;
    logic perr_oe_reg, perr_oe_next;
    logic [EV_W-1:0] ev_src;
    logic cmd_ser, cmd_per, cmd_bme, cmd_mes, cmd_ios, cmd_step;

    // ----------------------------------------
    // Core domain: register update
    // ----------------------------------------
    assign ev_pulse = ev_s2_reg ^ ev_s3_reg;
    assign pci_wr_take = wreq_sync_reg[1] ^ wreq_sync_reg[2];

    always_comb begin
        ev_set = '0;
        ev_set[BIT_PARITY_ERROR_DETECTED] = ev_pulse[EV_PARITY];
        ev_set[BIT_SYSTEM_ERROR_SIGNALLED] = ev_pulse[EV_SERR];
        ev_set[BIT_RECEIVED_MASTER_ABORT] = ev_pulse[EV_MASTER_ABORT];
        ev_set[BIT_RECEIVED_TARGET_ABORT] = ev_pulse[EV_TABORT_RCV];
        ev_set[BIT_SIGNALLED_TARGET_ABORT] = ev_pulse[EV_TABORT_SIG];
        ev_set[BIT_MASTER_DATA_PARITY_FLAG] = ev_pulse[EV_MASTER_PERR]
            & reg_reg[BIT_PARITY_RESPONSE_ENABLE];
        wr_val = reg_reg;
        if (ipb_wr_i) begin
            // Processor side may also set the two capability bits
            wr_val = apply_write(wr_val, ipb_wdata_i, ipb_be_i,
                PSCR_RW_BOTH_MASK | PSCR_RW_PB_MASK);
        end
        if (pci_wr_take) begin
            wr_val = apply_write(wr_val, pwd_reg, pbe_reg,
                PSCR_RW_BOTH_MASK);
        end
        // Clears asked for this cycle, whether the flag is set or not
        clr_vec = '0;
        if (ipb_wr_i) begin
            clr_vec = ipb_wdata_i & be_mask(ipb_be_i);
        end
        if (pci_wr_take) begin
            clr_vec = clr_vec | (pwd_reg & be_mask(pbe_reg));
        end
        clr_vec = clr_vec & PSCR_W1C_MASK;
        reg_next = wr_val | ev_set;
        if (rst_i || sw_reset_i) begin
            // Fixed fields take their values here; no write mask reaches them
            reg_next = PSCR_RESET_VAL;
        end
        rdata_next = reg_next;
        wack_next = wreq_sync_reg[1];
        snd_next = snd_reg;
        snap_next = snap_reg;
        // Push a new copy only when the previous one was taken
        if (snd_reg == rack_sync_reg[1] && snap_reg != reg_reg) begin
            snd_next = ~snd_reg;
            snap_next = reg_reg;
        end
        if (rst_i) begin
            wack_next = 1'b0;
            snd_next = 1'b0;
            snap_next = PSCR_RESET_VAL;
        end
    end

    always_ff @(posedge core_clk_i) begin
        reg_reg <= reg_next;
        rdata_reg <= rdata_next;
        wack_reg <= wack_next;
        snd_reg <= snd_next;
        snap_reg <= snap_next;
        wreq_sync_reg <= rst_i ? 3'h0 : {wreq_sync_reg[1:0], wreq_reg};
        ev_s1_reg <= rst_i ? '0 : ev_tgl_reg;
        ev_s2_reg <= rst_i ? '0 : ev_s1_reg;
        ev_s3_reg <= rst_i ? '0 : ev_s2_reg;
        rack_sync_reg <= rst_i ? 2'h0 : {rack_sync_reg[0], rack_reg};
    end

    assign ipb_rdata_o = rdata_reg;

    // ----------------------------------------
    // PCI domain: writes, events, pins
    // ----------------------------------------
    // Reset reaches this domain through two flops; no edge is assumed
    // while the link clock is stopped
    assign pci_cfg_busy_o = wreq_reg ^ wack_sync_reg[1];
    assign cmd_ser = cmd_s2_reg[0];
    assign cmd_per = cmd_s2_reg[1];
    assign cmd_bme = cmd_s2_reg[2];
    assign cmd_mes = cmd_s2_reg[3];
    assign cmd_ios = cmd_s2_reg[4];
    assign cmd_step = cmd_s2_reg[5];

    always_comb begin
        ev_src = pci_event_i;
        // SERR# counts as signalled only when actually driven
        ev_src[EV_SERR] = serr_req_i & cmd_ser;
        wreq_next = wreq_reg;
        pwd_next = pwd_reg;
        pbe_next = pbe_reg;
        // Held stable while in flight; writes while busy are dropped
        if (pci_cfg_wr_i && !pci_cfg_busy_o) begin
            wreq_next = ~wreq_reg;
            pwd_next = pci_cfg_wdata_i;
            pbe_next = pci_cfg_be_i;
        end
        ev_tgl_next = ev_tgl_reg ^ ev_src;
        rack_next = snd_sync_reg[1];
        prd_next = prd_reg;
        if (snd_sync_reg[1] != snd_sync_reg[2]) begin
            prd_next = snap_reg;
        end
        serr_oe_next = serr_req_i & cmd_ser;
        perr_oe_next = perr_req_i & cmd_per;
        if (prst_reg[1]) begin
            wreq_next = 1'b0;
            pwd_next = '0;
            pbe_next = 4'h0;
            ev_tgl_next = '0;
            rack_next = 1'b0;
            prd_next = PSCR_RESET_VAL;
            serr_oe_next = 1'b0;
            perr_oe_next = 1'b0;
        end
    end

    always_ff @(posedge pci_clk_i) begin
        prst_reg <= {prst_reg[0], rst_i};
        wreq_reg <= wreq_next;
        pwd_reg <= pwd_next;
        pbe_reg <= pbe_next;
        ev_tgl_reg <= ev_tgl_next;
        rack_reg <= rack_next;
        prd_reg <= prd_next;
        serr_oe_reg <= serr_oe_next;
        perr_oe_reg <= perr_oe_next;
        wack_sync_reg <= prst_reg[1] ? 2'h0 : {wack_sync_reg[0], wack_reg};
        snd_sync_reg <= prst_reg[1] ? 3'h0 : {snd_sync_reg[1:0], snd_reg};
        cmd_s1_reg <= prst_reg[1] ? '0 : {
            reg_reg[BIT_STEPPING_ENABLE], reg_reg[BIT_IO_SPACE_ENABLE],
            reg_reg[BIT_MEMORY_SPACE_ENABLE], reg_reg[BIT_BUS_MASTER_ENABLE],
            reg_reg[BIT_PARITY_RESPONSE_ENABLE],
            reg_reg[BIT_SYSTEM_ERROR_ENABLE]};
        cmd_s2_reg <= prst_reg[1] ? '0 : cmd_s1_reg;
    end

    assign pci_cfg_rdata_o = prd_reg;
    assign master_grant_o = master_req_i & cmd_bme;
    // A target that does not claim is ended by master abort
    assign target_claim_o = (mem_hit_i & cmd_mes)
        | (io_hit_i & cmd_ios);
    assign stepping_enable_o = cmd_step;
    assign fast_b2b_enable_o = reg_reg[BIT_FAST_B2B_ENABLE];
    assign serr_n_o = 1'b0;
    assign serr_oe_o = serr_oe_reg;
    assign perr_n_o = 1'b0;
    assign perr_oe_o = perr_oe_reg;

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    AST_RESET_LOAD: assert property (@(posedge core_clk_i)
        $past(sw_reset_i) |-> reg_reg == PSCR_RESET_VAL)
        else $error("register not loaded with reset pattern");

    AST_FLAG_CLEAR_CAUSE: assert property (@(posedge core_clk_i)
        disable iff (rst_i)
        |($past(reg_reg) & ~reg_reg & PSCR_W1C_MASK)
            && !$past(sw_reset_i)
        |-> $past(ipb_wr_i) || $past(pci_wr_take))
        else $error("status flag cleared without a write");

    AST_FIXED_BITS: assert property (@(posedge core_clk_i)
        disable iff (rst_i)
        (reg_reg & ~(PSCR_W1C_MASK | PSCR_RW_BOTH_MASK | PSCR_RW_PB_MASK))
            == PSCR_FIXED_VAL)
        else $error("fixed bits changed");

    AST_PB_ONLY_BITS: assert property (@(posedge core_clk_i)
        disable iff (rst_i)
        $changed(reg_reg[22:21]) && !$past(sw_reset_i) |-> $past(ipb_wr_i))
        else $error("capability bits changed without processor write");

    AST_PARITY_SETS: assert property (@(posedge core_clk_i)
        disable iff (rst_i || sw_reset_i)
        ev_pulse[EV_PARITY] |=> reg_reg[BIT_PARITY_ERROR_DETECTED])
        else $error("parity event did not set flag");

    AST_MASTER_ABORT_SETS: assert property (@(posedge core_clk_i)
        disable iff (rst_i || sw_reset_i)
        ev_pulse[EV_MASTER_ABORT] |=> reg_reg[BIT_RECEIVED_MASTER_ABORT])
        else $error("master abort did not set flag");

    AST_SERR_SETS: assert property (@(posedge core_clk_i)
        disable iff (rst_i || sw_reset_i)
        ev_pulse[EV_SERR] |=> reg_reg[BIT_SYSTEM_ERROR_SIGNALLED])
        else $error("system error event did not set flag");

    AST_RTA_SETS: assert property (@(posedge core_clk_i)
        disable iff (rst_i || sw_reset_i)
        ev_pulse[EV_TABORT_RCV] |=> reg_reg[BIT_RECEIVED_TARGET_ABORT])
        else $error("received target abort did not set flag");

    AST_STA_SETS: assert property (@(posedge core_clk_i)
        disable iff (rst_i || sw_reset_i)
        ev_pulse[EV_TABORT_SIG] |=> reg_reg[BIT_SIGNALLED_TARGET_ABORT])
        else $error("signalled target abort did not set flag");

    AST_DPD_GATED: assert property (@(posedge core_clk_i)
        disable iff (rst_i)
        $rose(reg_reg[BIT_MASTER_DATA_PARITY_FLAG])
        |-> $past(reg_reg[BIT_PARITY_RESPONSE_ENABLE]))
        else $error("data parity flag set while response disabled");

    AST_SET_BEATS_CLEAR: assert property (@(posedge core_clk_i)
        disable iff (rst_i || sw_reset_i)
        ev_pulse[EV_TABORT_SIG] && clr_vec[BIT_SIGNALLED_TARGET_ABORT]
        |=> reg_reg[BIT_SIGNALLED_TARGET_ABORT])
        else $error("simultaneous clear lost the event");

    AST_SERR_HIZ: assert property (@(posedge pci_clk_i)
        disable iff (prst_reg[1])
        !$past(cmd_ser) |-> !serr_oe_o)
        else $error("SERR driven while disabled");

    AST_PERR_GATED: assert property (@(posedge pci_clk_i)
        disable iff (prst_reg[1])
        perr_oe_o |-> $past(cmd_per) && $past(perr_req_i))
        else $error("PERR driven without cause");

    AST_CLAIM: assert property (@(posedge pci_clk_i)
        disable iff (prst_reg[1])
        mem_hit_i && !io_hit_i && !cmd_mes |-> !target_claim_o)
        else $error("memory access claimed while disabled");

    AST_IO_CLAIM: assert property (@(posedge pci_clk_i)
        disable iff (prst_reg[1])
        io_hit_i && !mem_hit_i && !cmd_ios |-> !target_claim_o)
        else $error("I/O access claimed while disabled");

    AST_GRANT_GATED: assert property (@(posedge pci_clk_i)
        disable iff (prst_reg[1])
        master_req_i && !cmd_bme |-> !master_grant_o)
        else $error("master start granted while disabled");

    COV_PCI_WRITE: cover property (@(posedge core_clk_i)
        disable iff (rst_i) pci_wr_take);
    COV_BOTH_WRITE: cover property (@(posedge core_clk_i)
        disable iff (rst_i) pci_wr_take && ipb_wr_i);
    COV_SERR: cover property (@(posedge pci_clk_i)
        disable iff (prst_reg[1]) serr_oe_o);
    COV_SET_BEATS_CLEAR: cover property (@(posedge core_clk_i)
        disable iff (rst_i) ev_pulse[EV_TABORT_SIG] && clr_vec[27]);

endmodule

// File: design/pscr_pkg.sv
// Constants for the PCI status/command configuration register.
// Assumes one core clock domain and one PCI link clock domain.
package pscr_pkg;

    // ----------------------------------------
    // Register layout
    // ----------------------------------------
    localparam int PSCR_W = 32;
    localparam logic [31:0] PSCR_RESET_VAL = 32'h02900080;
    localparam logic [31:0] PSCR_W1C_MASK = 32'hF9000000;
    localparam logic [31:0] PSCR_RW_BOTH_MASK = 32'h000001C7;
    localparam logic [31:0] PSCR_RW_PB_MASK = 32'h00600000;
    localparam logic [31:0] PSCR_FIXED_VAL = 32'h02900000;

    localparam int BIT_PARITY_ERROR_DETECTED = 31;
    localparam int BIT_SYSTEM_ERROR_SIGNALLED = 30;
    localparam int BIT_RECEIVED_MASTER_ABORT = 29;
    localparam int BIT_RECEIVED_TARGET_ABORT = 28;
    localparam int BIT_SIGNALLED_TARGET_ABORT = 27;
    localparam int BIT_MASTER_DATA_PARITY_FLAG = 24;
    localparam int BIT_USER_FUNCTION_CAPABLE = 22;
    localparam int BIT_HIGH_SPEED_CAPABLE = 21;
    localparam int BIT_FAST_B2B_ENABLE = 9;
    localparam int BIT_SYSTEM_ERROR_ENABLE = 8;
    localparam int BIT_STEPPING_ENABLE = 7;
    localparam int BIT_PARITY_RESPONSE_ENABLE = 6;
    localparam int BIT_BUS_MASTER_ENABLE = 2;
    localparam int BIT_MEMORY_SPACE_ENABLE = 1;
    localparam int BIT_IO_SPACE_ENABLE = 0;

    // ----------------------------------------
    // Hardware events from the PCI domain
    // ----------------------------------------
    localparam int EV_W = 6;
    localparam int EV_PARITY = 0;
    localparam int EV_SERR = 1;
    localparam int EV_MASTER_ABORT = 2;
    localparam int EV_TABORT_RCV = 3;
    localparam int EV_TABORT_SIG = 4;
    localparam int EV_MASTER_PERR = 5;

    // Command bits carried to the PCI domain
    localparam int CMD_W = 6;

endpackage

// File: tb/pscr_pci_model.sv
// PCI-side partner: configuration master and transaction engine requests.
// Assumes the bench supplies the link clock and calls the tasks in turn.
`timescale 1ns/1ps

module pscr_pci_model (
    input wire logic pci_clk_i,
    input wire logic busy_i,
    output logic wr_o,
    output logic [3:0] be_o,
    output logic [pscr_pkg::PSCR_W-1:0] wdata_o,
    output logic [pscr_pkg::EV_W-1:0] event_o,
    output logic [4:0] req_o
);
    import pscr_pkg::*;
    int n;

    initial begin
        wr_o = 1'b0;
        be_o = 4'h0;
        wdata_o = 32'h0;
        event_o = 6'h0;
        req_o = 5'h0;
    end

    // ----------------------------------------
    // Configuration write, held until taken
    // ----------------------------------------
    task automatic cfg_write(input logic [31:0] wd, input logic [3:0] be,
            output logic ok);
        n = 0;
        @(negedge pci_clk_i);
        while (busy_i !== 1'b0 && n < 60) begin
            @(negedge pci_clk_i);
            n++;
        end
        wr_o = 1'b1;
        be_o = be;
        wdata_o = wd & ~32'h000FFC00;
        @(posedge pci_clk_i);
        @(negedge pci_clk_i);
        wr_o = 1'b0;
        // Released data is scrambled so a stale capture cannot pass
        wdata_o = ~wdata_o;
        n = 0;
        while (busy_i !== 1'b0 && n < 60) begin
            @(negedge pci_clk_i);
            n++;
        end
        ok = (n < 60);
    endtask

    task automatic pulse(input int i);
        @(negedge pci_clk_i);
        event_o[i] = 1'b1;
        @(negedge pci_clk_i);
        event_o = 6'h0;
    endtask

    // Order: serr, perr, master request, memory hit, I/O hit
    task automatic pins(input logic [4:0] p);
        @(negedge pci_clk_i);
        req_o = p;
    endtask
endmodule

// File: tb/tb_pci_status_command_register.sv
// Self-checking bench of the status/command register, random and corners.
// Assumes pscr_top with its assertions and the PCI-side partner model.
`timescale 1ns/1ps

module tb_pci_status_command_register;
    import pscr_pkg::*;
    logic core_clk = 1'b0;
    logic pci_clk = 1'b0;
    logic rst = 1'b1;
    logic sw_rst = 1'b0;
    logic ipb_wr = 1'b0;
    logic [3:0] ipb_be = 4'h0;
    logic [31:0] ipb_wd = 32'h0;
    logic [31:0] ipb_rd, pci_rd, exp_reg, r, pwd;
    logic [3:0] be, pbe;
    logic [5:0] ev;
    logic [4:0] p, rq;
    logic busy, pwr, grant, claim, step, fbb, serr_n, serr_oe;
    logic perr_n, perr_oe, ok;
    int err_count = 0;
    int n_compared = 0;
    int seed = 86;
    int idx;
    int map[6] = '{31, -1, 29, 28, 27, 24};

    always #2 core_clk = ~core_clk;
    // Offset start keeps the link clock out of phase with the core clock
    always begin
        if ($time == 0) #1.3;
        #6 pci_clk = ~pci_clk;
    end

    pscr_top i_dut (.core_clk_i(core_clk), .rst_i(rst), .sw_reset_i(sw_rst),
        .ipb_wr_i(ipb_wr), .ipb_be_i(ipb_be), .ipb_wdata_i(ipb_wd),
        .ipb_rdata_o(ipb_rd), .pci_clk_i(pci_clk), .pci_cfg_wr_i(pwr),
        .pci_cfg_be_i(pbe), .pci_cfg_wdata_i(pwd), .pci_cfg_busy_o(busy),
        .pci_cfg_rdata_o(pci_rd), .pci_event_i(ev), .serr_req_i(rq[4]),
        .perr_req_i(rq[3]), .master_req_i(rq[2]), .mem_hit_i(rq[1]),
        .io_hit_i(rq[0]), .master_grant_o(grant), .target_claim_o(claim),
        .stepping_enable_o(step), .fast_b2b_enable_o(fbb),
        .serr_n_o(serr_n), .serr_oe_o(serr_oe), .perr_n_o(perr_n),
        .perr_oe_o(perr_oe));

    pscr_pci_model i_pci (.pci_clk_i(pci_clk), .busy_i(busy), .wr_o(pwr),
        .be_o(pbe), .wdata_o(pwd), .event_o(ev), .req_o(rq));

    // ----------------------------------------
    // Expectation and check helpers
    // ----------------------------------------
    function automatic logic [31:0] nxt(input logic [31:0] old,
            input logic [31:0] wd, input logic [3:0] b, input logic pb);
        logic [31:0] m;
        logic [31:0] rw;
        m = {{8{b[3]}}, {8{b[2]}}, {8{b[1]}}, {8{b[0]}}};
        rw = PSCR_RW_BOTH_MASK | (pb ? PSCR_RW_PB_MASK : 32'h0);
        rw = rw & m;
        return ((old & ~rw) | (wd & rw)) & ~(wd & PSCR_W1C_MASK & m);
    endfunction

    task automatic chk(input string nm, input logic [31:0] e,
            input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            $display("[ERR] %s expected %h seen %h", nm, e, g);
            err_count++;
        end
    endtask

    task automatic ipbw(input logic [31:0] wd, input logic [3:0] b);
        @(negedge core_clk);
        ipb_wr = 1'b1;
        ipb_wd = wd;
        ipb_be = b;
        @(negedge core_clk);
        ipb_wr = 1'b0;
        ipb_wd = ~wd;
        exp_reg = nxt(exp_reg, wd, b, 1'b1);
    endtask

    task automatic pciw(input logic [31:0] wd, input logic [3:0] b);
        i_pci.cfg_write(wd, b, ok);
        chk("pci_ack", 32'h1, {31'h0, ok});
        exp_reg = nxt(exp_reg, wd & ~32'h000FFC00, b, 1'b0);
        @(negedge core_clk);
        chk("pci_write", exp_reg, ipb_rd);
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge pci_clk);
        @(negedge core_clk);
    endtask

    task automatic end_sim;
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    initial begin
        #60000;
        err_count++;
        end_sim();
    end

    initial begin
        // Held over six link cycles so both domains see the reset
        repeat (6) @(negedge pci_clk);
        @(negedge core_clk);
        rst = 1'b0;
        exp_reg = PSCR_RESET_VAL;
        cyc(4);
        chk("reset_core", exp_reg, ipb_rd);
        chk("reset_pci", exp_reg, pci_rd);
        $display("test reset done");
        for (int e = 0; e < 2; e++) begin
            ipbw(32'h80 | (32'(e) << 6), 4'hF);
            cyc(4);
            for (int i = 0; i < 6; i++) begin
                i_pci.pulse(i);
                cyc(3);
                if (map[i] >= 0 && (i != 5 || e == 1)) begin
                    exp_reg[map[i]] = 1'b1;
                end
                chk("event_flag", exp_reg, ipb_rd);
            end
            pciw(32'hF9000000 | (exp_reg & 32'h1C7), 4'hF);
        end
        // Clearing writes held while a signalled abort arrives
        @(negedge core_clk);
        ipb_wr = 1'b1;
        ipb_be = 4'hF;
        ipb_wd = 32'h08000000 | (exp_reg & 32'h006001C7);
        i_pci.pulse(4);
        idx = 0;
        repeat (12) begin
            @(negedge core_clk);
            if (ipb_rd[27] === 1'b1) idx++;
        end
        ipb_wr = 1'b0;
        chk("set_beats_clear", 32'h1, 32'(idx));
        chk("after_clear", exp_reg, ipb_rd);
        $display("test events done");
        // Reserved positions stay zero on the writer side as well
        ipbw(32'hFFF003FF, 4'hF);
        chk("all_ones", exp_reg, ipb_rd);
        repeat (16) begin
            r = $random(seed);
            be = 4'($random(seed));
            idx = int'(r[10:8]) % 6;
            i_pci.pulse(idx);
            cyc(3);
            if (map[idx] >= 0 && (idx != 5 || exp_reg[6])) begin
                exp_reg[map[idx]] = 1'b1;
            end
            ipbw(r & ~32'h000FFC00, be);
            chk("ipb_write", exp_reg, ipb_rd);
        end
        $display("test processor writes done");
        repeat (8) begin
            r = $random(seed);
            be = 4'($random(seed));
            pciw(r, be);
            cyc(8);
            chk("pci_copy", exp_reg, pci_rd);
        end
        $display("test pci writes done");
        repeat (8) begin
            r = $random(seed);
            p = 5'($random(seed));
            i_pci.pins(5'h0);
            ipbw(r & 32'h000001C7, 4'hF);
            cyc(6);
            i_pci.pins(p);
            cyc(4);
            if (p[4] & exp_reg[8]) exp_reg[30] = 1'b1;
            chk("serr_oe", {31'h0, p[4] & exp_reg[8]},
                {31'h0, serr_oe});
            chk("perr_oe", {31'h0, p[3] & exp_reg[6]},
                {31'h0, perr_oe});
            chk("grant", {31'h0, p[2] & exp_reg[2]}, {31'h0, grant});
            chk("claim", {31'h0, (p[1] & exp_reg[1]) | (p[0] & exp_reg[0])},
                {31'h0, claim});
            chk("stepping", {31'h0, exp_reg[7]}, {31'h0, step});
            chk("b2b", 32'h0, {31'h0, fbb});
            chk("pin_level", 32'h0, {30'h0, serr_n, perr_n});
            chk("serr_flag", exp_reg, ipb_rd);
        end
        $display("test pins done");
        i_pci.pins(5'h0);
        ipbw(32'h00600147, 4'hF);
        cyc(6);
        @(negedge core_clk);
        sw_rst = 1'b1;
        @(negedge core_clk);
        sw_rst = 1'b0;
        exp_reg = PSCR_RESET_VAL;
        chk("sw_reset", exp_reg, ipb_rd);
        $display("test software reset done");
        end_sim();
    end
endmodule
